// [src/alu_defs.svh]
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
`define UNSIGNED_QUOTIENT_OP_A_ZERO 6'd3
`define UNSIGNED_QUOTIENT_OP_A_OVF 6'd6
`define UNSIGNED_QUOTIENT_OP_A_NORM 6'd14
`define UNSIGNED_QUOTIENT_OP_R_ZERO 6'd3
`define UNSIGNED_QUOTIENT_OP_R_OVF 6'd5
`define UNSIGNED_QUOTIENT_OP_R_NORM 6'd13
`define DIVUL_ZERO 6'd3
`define DIVUL_OVF 6'd5
`define DIVUL_NORM 6'd21
`define UNSIGNED_PRODUCT_OP_B_ZERO 6'd3
`define UNSIGNED_PRODUCT_OP_B_NORM 6'd7
`define UNSIGNED_PRODUCT_OP_W_ZERO 6'd3
`define UNSIGNED_PRODUCT_OP_W_NORM 6'd11
`define UNSIGNED_PRODUCT_OP_M_ZERO 6'd4
`define UNSIGNED_PRODUCT_OP_M_NORM 6'd12
`define DIVS_A_ZERO 6'd3
`define DIVS_A_OVF_PRE 6'd8
`define DIVS_A_OVF_POST 6'd18
`define DIVS_A_NORM 6'd18
`define DIVSL_P_ZERO 6'd4
`define DIVSL_P_OVF_PRE 6'd10
`define DIVSL_P_OVF_POST 6'd29
`define DIVSL_P_NORM 6'd30
`define DIVSL_N_ZERO 6'd4
`define DIVSL_N_OVF_PRE 6'd11
`define DIVSL_N_OVF_POST 6'd30
`define DIVSL_N_NORM 6'd31
`define MULS_B_ZERO 6'd3
`define MULS_B_POS 6'd12
`define MULS_B_NEG 6'd13
`define MULS_W_ZERO 6'd3
`define MULS_W_POS 6'd16
`define MULS_W_NEG 6'd19
`define LOGIC_CYC 6'd2
`define LOGIC_L_CYC 6'd5
`define TWOS_COMPLEMENT_WORD_OP_MEM_CYC 6'd3
`endif

// [src/alu_pkg.sv]
package alu_pkg;
    typedef enum logic [4:0] {
        OP_UNSIGNED_QUOTIENT_ACC,
        OP_UNSIGNED_QUOTIENT_REG,
        OP_UNSIGNED_LONG_QUOTIENT,
        OP_UNSIGNED_PRODUCT_ACC,
        OP_UNSIGNED_WORD_PRODUCT_ACC,
        OP_UNSIGNED_WORD_PRODUCT_MEM,
        OP_SIGNED_QUOTIENT_ACC,
        OP_SIGNED_LONG_QUOTIENT,
        OP_SIGNED_PRODUCT_ACC,
        OP_SIGNED_WORD_PRODUCT_REG,
        OP_AND_B,
        OP_OR_B,
        OP_XOR_B,
        OP_AND_W_ACC,
        OP_OR_W_ACC,
        OP_XOR_W_ACC,
        OP_NOT_B,
        OP_NOT_W,
        OP_AND_L,
        OP_OR_L,
        OP_XOR_L,
        OP_TWOS_COMPLEMENT,
        OP_TWOS_COMPLEMENT_WORD
    } alu_op_t;
    typedef enum {
        ST_IDLE,
        ST_BUSY
    } alu_state_t;
    typedef struct packed {
        logic [5:0] count;
        logic [31:0] result;
        logic [15:0] remainder;
        logic n;
        logic z;
        logic v;
        logic c;
        logic n_we;
        logic z_we;
        logic v_we;
        logic c_we;
        logic busy;
        logic done;
        logic [5:0] cycles;
    } alu_core_t;
endpackage

// [src/cycle_timer.sv]
`timescale 1ns/1ps
module cycle_timer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [5:0] cycles_in,
    output logic expire_out
);
    typedef struct packed {
        logic [5:0] left;
        logic expire;
    } timer_t;
    timer_t st_reg;
    timer_t st_next;
    always_comb begin
        st_next = st_reg;
        st_next.expire = 1'b0;
        if (load_in) begin
            st_next.left = cycles_in - 6'd1;
        end else if (st_reg.left != 6'd0) begin
            st_next.left = st_reg.left - 6'd1;
            st_next.expire = (st_reg.left == 6'd1);
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign expire_out = st_reg.expire;
endmodule

// [src/muldiv_logic_negate_alu.sv]
`timescale 1ns/1ps
`include "alu_defs.svh"
module muldiv_logic_negate_alu (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire alu_pkg::alu_op_t op_in,
    input wire logic [31:0] acc_in,
    input wire logic [31:0] operand_in,
    input wire logic mem_operand_in,
    input wire logic [5:0] addr_cycles_in,
    input wire logic [5:0] access_corr_in,
    input wire logic c_flag_in,
    output logic busy_out,
    output logic done_out,
    output logic [31:0] result_out,
    output logic [15:0] remainder_out,
    output logic flag_n_out,
    output logic flag_z_out,
    output logic flag_v_out,
    output logic flag_c_out,
    output logic flag_n_we_out,
    output logic flag_z_we_out,
    output logic flag_v_we_out,
    output logic flag_c_we_out,
    output logic [5:0] cycles_out
);
    alu_pkg::alu_core_t st_reg;
    alu_pkg::alu_core_t st_next;
    logic load;
    logic [5:0] load_cycles;
    logic expire;

    // ********************
    // Operand helpers
    // ********************
    function automatic logic [5:0] corr_total(input logic twice, input logic [5:0] corr);
        corr_total = twice ? 6'((corr << 1)) : corr;
    endfunction

    function automatic logic [15:0] sabs16(input logic [15:0] x);
        sabs16 = x[15] ? 16'(-x) : x;
    endfunction

    function automatic logic [31:0] sabs32(input logic [31:0] x);
        sabs32 = x[31] ? 32'(-x) : x;
    endfunction

    logic [7:0] acc_b;
    logic [7:0] acc_up_b;
    logic [15:0] acc_w;
    logic [15:0] acc_up_w;
    logic [7:0] opr_b;
    logic [15:0] opr_w;
    logic [7:0] acc_low_part;
    logic [15:0] acc_upper_part;
    assign acc_b = acc_in[7:0];
    assign acc_up_b = acc_in[15:8];
    assign acc_w = acc_in[15:0];
    assign acc_up_w = acc_in[31:16];
    assign opr_b = operand_in[7:0];
    assign opr_w = operand_in[15:0];
    assign acc_low_part = acc_in[7:0];
    assign acc_upper_part = acc_in[31:16];

    // ********************
    // Issue logic
    // ********************
    always_comb begin
        logic [15:0] q16;
        logic [15:0] r16;
        logic [31:0] q32;
        logic [31:0] r32;
        logic [15:0] sq16;
        logic [31:0] sq32;
        logic [31:0] prod;
        logic [15:0] ua;
        logic [15:0] ub;
        logic [31:0] ul;
        logic neg;
        logic zero_d;
        logic ovf;
        logic pre_ovf;
        logic [31:0] lres;
        logic [5:0] cyc;
        q16 = '0;
        r16 = '0;
        q32 = '0;
        r32 = '0;
        sq16 = '0;
        sq32 = '0;
        prod = '0;
        ua = '0;
        ub = '0;
        ul = '0;
        neg = 1'b0;
        zero_d = 1'b0;
        ovf = 1'b0;
        pre_ovf = 1'b0;
        lres = '0;
        cyc = `LOGIC_CYC;
        st_next = st_reg;
        st_next.done = 1'b0;
        load = 1'b0;
        load_cycles = 6'd1;
        if (st_reg.busy) begin
            if (expire) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
        end else if (start_in) begin
            st_next.n_we = 1'b0;
            st_next.z_we = 1'b0;
            st_next.v_we = 1'b0;
            st_next.c_we = 1'b0;
            st_next.remainder = '0;
            st_next.n = st_reg.n;
            st_next.z = st_reg.z;
            st_next.v = 1'b0;
            st_next.c = c_flag_in;
            case (op_in)
                alu_pkg::OP_UNSIGNED_QUOTIENT_ACC, alu_pkg::OP_UNSIGNED_QUOTIENT_REG: begin
                    zero_d = (op_in == alu_pkg::OP_UNSIGNED_QUOTIENT_ACC) ?
                             (acc_low_part == 8'h00) : (opr_b == 8'h00);
                    ub = (op_in == alu_pkg::OP_UNSIGNED_QUOTIENT_ACC) ?
                         {8'h00, acc_low_part} : {8'h00, opr_b};
                    ua = (op_in == alu_pkg::OP_UNSIGNED_QUOTIENT_ACC) ? acc_upper_part : acc_w;
                    if (!zero_d) begin
                        q16 = ua / ub;
                        r16 = ua % ub;
                    end
                    ovf = !zero_d && (q16[15:8] != 8'h00);
                    if (op_in == alu_pkg::OP_UNSIGNED_QUOTIENT_ACC) begin
                        cyc = zero_d ? `UNSIGNED_QUOTIENT_OP_A_ZERO : ovf ? `UNSIGNED_QUOTIENT_OP_A_OVF : `UNSIGNED_QUOTIENT_OP_A_NORM;
                    end else begin
                        cyc = zero_d ? `UNSIGNED_QUOTIENT_OP_R_ZERO : ovf ? `UNSIGNED_QUOTIENT_OP_R_OVF : `UNSIGNED_QUOTIENT_OP_R_NORM;
                    end
                    st_next.result = (zero_d || ovf) ? acc_in : {acc_in[31:16], r16[7:0], q16[7:0]};
                    st_next.remainder = {8'h00, r16[7:0]};
                end
                alu_pkg::OP_UNSIGNED_LONG_QUOTIENT: begin
                    zero_d = (opr_w == 16'h0000);
                    if (!zero_d) begin
                        q32 = acc_in / {16'h0000, opr_w};
                        r32 = acc_in % {16'h0000, opr_w};
                    end
                    ovf = !zero_d && (q32[31:16] != 16'h0000);
                    cyc = zero_d ? `DIVUL_ZERO : ovf ? `DIVUL_OVF : `DIVUL_NORM;
                    st_next.result = (zero_d || ovf) ? acc_in : {16'h0000, q32[15:0]};
                    st_next.remainder = r32[15:0];
                end
                alu_pkg::OP_SIGNED_QUOTIENT_ACC: begin
                    zero_d = (acc_low_part == 8'h00);
                    ua = sabs16(acc_upper_part);
                    ub = sabs16({{8{acc_low_part[7]}}, acc_low_part});
                    neg = acc_upper_part[15] ^ acc_low_part[7];
                    pre_ovf = !zero_d && (ua[15:8] >= ub[7:0]);
                    if (!zero_d) begin
                        q16 = ua / ub;
                        r16 = ua % ub;
                    end
                    sq16 = neg ? 16'(-q16) : q16;
                    ovf = !zero_d && (pre_ovf || (sq16[15:7] != {9{sq16[7]}}));
                    cyc = zero_d ? `DIVS_A_ZERO : pre_ovf ? `DIVS_A_OVF_PRE :
                          ovf ? `DIVS_A_OVF_POST : `DIVS_A_NORM;
                    r16 = acc_upper_part[15] ? 16'(-r16) : r16;
                    st_next.result = (zero_d || ovf) ? acc_in : {acc_in[31:16], r16[7:0], sq16[7:0]};
                    st_next.remainder = {8'h00, r16[7:0]};
                end
                alu_pkg::OP_SIGNED_LONG_QUOTIENT: begin
                    zero_d = (opr_w == 16'h0000);
                    ul = sabs32(acc_in);
                    ub = sabs16(opr_w);
                    neg = acc_in[31] ^ opr_w[15];
                    pre_ovf = !zero_d && (ul[31:16] >= ub);
                    if (!zero_d) begin
                        q32 = ul / {16'h0000, ub};
                        r32 = ul % {16'h0000, ub};
                    end
                    sq32 = neg ? 32'(-q32) : q32;
                    ovf = !zero_d && (pre_ovf || (sq32[31:15] != {17{sq32[15]}}));
                    if (!acc_in[31]) begin
                        cyc = zero_d ? `DIVSL_P_ZERO : pre_ovf ? `DIVSL_P_OVF_PRE :
                              ovf ? `DIVSL_P_OVF_POST : `DIVSL_P_NORM;
                    end else begin
                        cyc = zero_d ? `DIVSL_N_ZERO : pre_ovf ? `DIVSL_N_OVF_PRE :
                              ovf ? `DIVSL_N_OVF_POST : `DIVSL_N_NORM;
                    end
                    r32 = acc_in[31] ? 32'(-r32) : r32;
                    st_next.result = (zero_d || ovf) ? acc_in : {16'h0000, sq32[15:0]};
                    st_next.remainder = r32[15:0];
                end
                alu_pkg::OP_UNSIGNED_PRODUCT_ACC: begin
                    prod = {16'h0000, 16'(acc_up_b) * 16'(acc_b)};
                    cyc = (acc_up_b == 8'h00) ? `UNSIGNED_PRODUCT_OP_B_ZERO : `UNSIGNED_PRODUCT_OP_B_NORM;
                    st_next.result = {acc_in[31:16], prod[15:0]};
                end
                alu_pkg::OP_UNSIGNED_WORD_PRODUCT_ACC, alu_pkg::OP_UNSIGNED_WORD_PRODUCT_MEM: begin
                    if (op_in == alu_pkg::OP_UNSIGNED_WORD_PRODUCT_ACC) begin
                        prod = acc_up_w * acc_w;
                        cyc = (acc_up_w == 16'h0000) ? `UNSIGNED_PRODUCT_OP_W_ZERO : `UNSIGNED_PRODUCT_OP_W_NORM;
                    end else begin
                        prod = acc_w * opr_w;
                        cyc = 6'((opr_w == 16'h0000) ? `UNSIGNED_PRODUCT_OP_M_ZERO : `UNSIGNED_PRODUCT_OP_M_NORM) +
                              addr_cycles_in;
                    end
                    st_next.result = prod;
                end
                alu_pkg::OP_SIGNED_PRODUCT_ACC: begin
                    prod = 32'($signed({{8{acc_up_b[7]}}, acc_up_b}) *
                               $signed({{8{acc_b[7]}}, acc_b}));
                    neg = prod[15];
                    cyc = (acc_up_b == 8'h00) ? `MULS_B_ZERO :
                          neg ? `MULS_B_NEG : `MULS_B_POS;
                    st_next.result = {acc_in[31:16], prod[15:0]};
                end
                alu_pkg::OP_SIGNED_WORD_PRODUCT_REG: begin
                    prod = 32'($signed(acc_w) * $signed(opr_w));
                    neg = prod[31];
                    cyc = (opr_w == 16'h0000) ? `MULS_W_ZERO :
                          neg ? `MULS_W_NEG : `MULS_W_POS;
                    st_next.result = prod;
                end
                alu_pkg::OP_AND_B, alu_pkg::OP_OR_B, alu_pkg::OP_XOR_B, alu_pkg::OP_NOT_B: begin
                    lres[7:0] = (op_in == alu_pkg::OP_AND_B) ? (acc_b & opr_b) :
                                (op_in == alu_pkg::OP_OR_B) ? (acc_b | opr_b) :
                                (op_in == alu_pkg::OP_XOR_B) ? (acc_b ^ opr_b) : ~opr_b;
                    st_next.result = {acc_in[31:8], lres[7:0]};
                    st_next.n = lres[7];
                    st_next.z = (lres[7:0] == 8'h00);
                    {st_next.n_we, st_next.z_we, st_next.v_we} = 3'b111;
                end
                alu_pkg::OP_AND_W_ACC, alu_pkg::OP_OR_W_ACC, alu_pkg::OP_XOR_W_ACC,
                alu_pkg::OP_NOT_W: begin
                    lres[15:0] = (op_in == alu_pkg::OP_AND_W_ACC) ? (acc_up_w & acc_w) :
                                 (op_in == alu_pkg::OP_OR_W_ACC) ? (acc_up_w | acc_w) :
                                 (op_in == alu_pkg::OP_XOR_W_ACC) ? (acc_up_w ^ acc_w) :
                                 ~opr_w;
                    st_next.result = {acc_in[31:16], lres[15:0]};
                    st_next.n = lres[15];
                    st_next.z = (lres[15:0] == 16'h0000);
                    {st_next.n_we, st_next.z_we, st_next.v_we} = 3'b111;
                end
                alu_pkg::OP_AND_L, alu_pkg::OP_OR_L, alu_pkg::OP_XOR_L: begin
                    lres = (op_in == alu_pkg::OP_AND_L) ? (acc_in & operand_in) :
                           (op_in == alu_pkg::OP_OR_L) ? (acc_in | operand_in) :
                           (acc_in ^ operand_in);
                    cyc = `LOGIC_L_CYC;
                    st_next.result = lres;
                    st_next.n = lres[31];
                    st_next.z = (lres == 32'h0000_0000);
                    {st_next.n_we, st_next.z_we, st_next.v_we} = 3'b111;
                end
                alu_pkg::OP_TWOS_COMPLEMENT: begin
                    lres[7:0] = 8'(8'h00 - opr_b);
                    st_next.result = {24'h000000, lres[7:0]};
                    st_next.n = lres[7];
                    st_next.z = (lres[7:0] == 8'h00);
                    st_next.v = (opr_b == 8'h80);
                    st_next.c = (opr_b != 8'h00);
                    {st_next.n_we, st_next.z_we, st_next.v_we, st_next.c_we} = 4'b1111;
                end
                alu_pkg::OP_TWOS_COMPLEMENT_WORD: begin
                    lres[15:0] = 16'(16'h0000 - opr_w);
                    if (mem_operand_in) begin
                        cyc = 6'(`TWOS_COMPLEMENT_WORD_OP_MEM_CYC + addr_cycles_in +
                                 corr_total(1'b1, access_corr_in));
                    end
                    st_next.result = {16'h0000, lres[15:0]};
                    st_next.n = lres[15];
                    st_next.z = (lres[15:0] == 16'h0000);
                    st_next.v = (opr_w == 16'h8000);
                    st_next.c = (opr_w != 16'h0000);
                    {st_next.n_we, st_next.z_we, st_next.v_we, st_next.c_we} = 4'b1111;
                end
                default: begin
                    st_next.result = acc_in;
                end
            endcase
            if (op_in inside {alu_pkg::OP_UNSIGNED_QUOTIENT_ACC, alu_pkg::OP_UNSIGNED_QUOTIENT_REG,
                              alu_pkg::OP_UNSIGNED_LONG_QUOTIENT, alu_pkg::OP_SIGNED_QUOTIENT_ACC,
                              alu_pkg::OP_SIGNED_LONG_QUOTIENT}) begin
                st_next.v = ovf || zero_d;
                st_next.c = zero_d;
                st_next.v_we = 1'b1;
                st_next.c_we = 1'b1;
                if (mem_operand_in) begin
                    cyc = 6'(cyc + corr_total(!(zero_d || ovf), access_corr_in));
                end
            end
            st_next.cycles = cyc;
            st_next.busy = 1'b1;
            load = 1'b1;
            load_cycles = cyc;
        end
    end

    cycle_timer u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(load),
        .cycles_in(load_cycles),
        .expire_out(expire)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************
    // Checks
    // ********************
    mul_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_UNSIGNED_PRODUCT_ACC) |=>
        !flag_n_we_out && !flag_z_we_out && !flag_v_we_out && !flag_c_we_out)
        else $error("multiply touched flags");
    unsigned_product_op_byte_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_UNSIGNED_PRODUCT_ACC &&
         acc_in[15:8] == 8'h00) |=> (cycles_out == 6'd3))
        else $error("byte multiply count wrong");
    unsigned_quotient_op_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_UNSIGNED_QUOTIENT_ACC &&
         acc_in[7:0] == 8'h00) |=> (cycles_out == 6'd3) && flag_c_out)
        else $error("zero divide count wrong");
    logic_v_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_AND_L) |=>
        !flag_v_out && flag_v_we_out && !flag_c_we_out && cycles_out == 6'd5)
        else $error("long logic flags wrong");
    neg_byte_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_TWOS_COMPLEMENT) |=>
        result_out[7:0] == 8'(8'h00 - $past(operand_in[7:0])))
        else $error("negate result wrong");
    done_time_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_UNSIGNED_PRODUCT_ACC &&
         acc_in[15:8] != 8'h00 && !mem_operand_in) |=> ##7 done_out)
        else $error("done not on time");
    byte_logic_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_XOR_B) |=>
        flag_z_out == (result_out[7:0] == 8'h00) && !flag_c_we_out)
        else $error("byte logic flags wrong");
    unsigned_product_op_word_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (start_in && !busy_out && op_in == alu_pkg::OP_UNSIGNED_WORD_PRODUCT_ACC &&
         acc_in[31:16] != 16'h0000) |=> (cycles_out == 6'd11))
        else $error("word multiply count wrong");

    assign busy_out = st_reg.busy;
    assign done_out = st_reg.done;
    assign result_out = st_reg.result;
    assign remainder_out = st_reg.remainder;
    assign flag_n_out = st_reg.n;
    assign flag_z_out = st_reg.z;
    assign flag_v_out = st_reg.v;
    assign flag_c_out = st_reg.c;
    assign flag_n_we_out = st_reg.n_we;
    assign flag_z_we_out = st_reg.z_we;
    assign flag_v_we_out = st_reg.v_we;
    assign flag_c_we_out = st_reg.c_we;
    assign cycles_out = st_reg.cycles;
endmodule

// [verif/flag_register_model.sv]
`timescale 1ns/1ps
// ****************
// Sequencer flag register
// ****************
module flag_register_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] flags_in,
    input wire logic [3:0] we_in,
    output logic [3:0] flags_out
);
    // Unwritten flags hold, so a stray enable shows up as a changed flag
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flags_out <= 4'h0;
        end else begin
            flags_out <= (flags_out & ~we_in) | (flags_in & we_in);
        end
    end
endmodule

// [verif/tb_muldiv_logic_negate_alu.sv]
`timescale 1ns/1ps
module tb_muldiv_logic_negate_alu;
    typedef struct packed {logic [5:0] cyc; logic [31:0] res; logic [31:0] m; logic [3:0] f;} exp_t;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0;
    alu_pkg::alu_op_t op_in = alu_pkg::OP_AND_B;
    logic [31:0] acc_in = 32'h0;
    logic [31:0] operand_in = 32'h0;
    logic mem_operand_in = 1'b0;
    logic [5:0] addr_cycles_in = 6'h0;
    logic [5:0] access_corr_in = 6'h0;
    logic done_out, busy_out;
    logic [31:0] result_out;
    logic [15:0] remainder_out;
    logic [5:0] cycles_out;
    logic [3:0] fo, fw, fl;
    exp_t q[$];
    logic [3:0] exp_f = 4'h0;
    logic [15:0] seed = 16'h004d;
    int n_mismatch = 0;
    int n_checks = 0;
    muldiv_logic_negate_alu muldiv_logic_negate_alu_inst (.clk_in, .rst_in, .start_in, .op_in,
        .acc_in, .operand_in, .mem_operand_in, .addr_cycles_in, .access_corr_in,
        .c_flag_in(fl[0]), .busy_out, .done_out, .result_out, .remainder_out,
        .flag_n_out(fo[3]), .flag_z_out(fo[2]), .flag_v_out(fo[1]), .flag_c_out(fo[0]),
        .flag_n_we_out(fw[3]), .flag_z_we_out(fw[2]), .flag_v_we_out(fw[1]),
        .flag_c_we_out(fw[0]), .cycles_out);
    flag_register_model flag_register_model_inst (.clk_in, .rst_in, .flags_in(fo), .we_in(fw),
        .flags_out(fl));
    always #20 clk_in = ~clk_in;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (e !== s) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************
    // Driver: note the expectation, start, wait bounded for done
    // ****************
    task automatic run(input alu_pkg::alu_op_t op, input logic [31:0] a, input logic [31:0] b,
        input logic [5:0] cyc, input logic [31:0] r, input int w, input logic [3:0] f,
        input logic [3:0] fm);
        int k;
        exp_f = (exp_f & ~fm) | (f & fm);
        q.push_back({cyc, r, (w == 32) ? 32'hffffffff : (32'h1 << w) - 32'h1, exp_f});
        op_in = op;
        acc_in = a;
        operand_in = b;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        check("busy", 32'h1, {31'h0, busy_out});
        k = 0;
        while (done_out !== 1'b1 && k < 60) begin
            @(negedge clk_in);
            k++;
        end
        if (k == 60) check("done", 32'h1, 32'h0);
        @(negedge clk_in);
        {mem_operand_in, addr_cycles_in, access_corr_in} = 13'h0;
        $display("test op %0d done", op);
    endtask
    // Watcher: done stands one cycle, so it is looked at on every falling edge
    always @(negedge clk_in) begin
        exp_t e;
        if (done_out === 1'b1) begin
            if (q.size() == 0) check("spare done", 32'h0, 32'h1);
            else begin
                e = q.pop_front();
                check("cycles", {26'h0, e.cyc}, {26'h0, cycles_out});
                check("busy", 32'h0, {31'h0, busy_out});
                check("result", e.res & e.m, result_out & e.m);
                check("flags", {28'h0, e.f}, {28'h0, fl});
            end
        end
    end
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        logic [7:0] a, b, r;
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        run(alu_pkg::OP_UNSIGNED_PRODUCT_ACC, 32'h5, 32'h0, 6'h3, 32'h0, 16, 0, 0);
        run(alu_pkg::OP_UNSIGNED_PRODUCT_ACC, 32'hff02, 32'h0, 6'h7, 32'h1fe, 16, 0, 0);
        run(alu_pkg::OP_UNSIGNED_WORD_PRODUCT_ACC, 32'h20003, 0, 6'hb, 6, 32, 0, 0);
        mem_operand_in = 1'b1;
        addr_cycles_in = 6'h2;
        run(alu_pkg::OP_UNSIGNED_WORD_PRODUCT_MEM, 32'h1234, 0, 6'h6, 0, 32, 0, 0);
        run(alu_pkg::OP_UNSIGNED_QUOTIENT_ACC, 32'h640000, 0, 6'h3, 32'h640000, 32, 3, 3);
        run(alu_pkg::OP_UNSIGNED_QUOTIENT_REG, 32'h64, 32'h7, 6'hd, 32'h20e, 16, 0, 3);
        check("remainder", 32'h2, {16'h0, remainder_out});
        run(alu_pkg::OP_UNSIGNED_QUOTIENT_REG, 32'h1000, 32'h2, 6'h5, 32'h1000, 32, 2, 3);
        {mem_operand_in, access_corr_in} = 7'h43;
        run(alu_pkg::OP_UNSIGNED_LONG_QUOTIENT, 32'h10000, 2, 6'h1b, 32'h8000, 16, 0, 3);
        {mem_operand_in, access_corr_in} = 7'h43;
        run(alu_pkg::OP_UNSIGNED_LONG_QUOTIENT, 32'h10000, 0, 6'h6, 32'h10000, 32, 3, 3);
        run(alu_pkg::OP_UNSIGNED_LONG_QUOTIENT, 32'h10001, 2, 6'h15, 32'h8000, 16, 0, 3);
        check("remainder", 32'h1, {16'h0, remainder_out});
        run(alu_pkg::OP_SIGNED_LONG_QUOTIENT, 32'h64, 32'h7, 6'h1e, 32'he, 16, 0, 3);
        run(alu_pkg::OP_SIGNED_LONG_QUOTIENT, 32'hffffff9c, 7, 6'h1f, 32'hfff2, 16, 0, 3);
        check("remainder", 32'hfffe, {16'h0, remainder_out});
        run(alu_pkg::OP_SIGNED_LONG_QUOTIENT, 32'h100000, 2, 6'ha, 32'h100000, 32, 2, 3);
        run(alu_pkg::OP_SIGNED_LONG_QUOTIENT, 32'hffffff9c, 0, 6'h4, 32'hffffff9c, 32, 3, 3);
        run(alu_pkg::OP_SIGNED_QUOTIENT_ACC, 32'h640000, 0, 6'h3, 32'h640000, 32, 3, 3);
        run(alu_pkg::OP_SIGNED_PRODUCT_ACC, 32'h203, 32'h0, 6'hc, 32'h6, 16, 0, 0);
        run(alu_pkg::OP_SIGNED_PRODUCT_ACC, 32'h2fd, 32'h0, 6'hd, 32'hfffa, 16, 0, 0);
        run(alu_pkg::OP_SIGNED_WORD_PRODUCT_REG, 3, 32'hfffe, 6'h13, 32'hfffffffa, 32, 0, 0);
        run(alu_pkg::OP_SIGNED_WORD_PRODUCT_REG, 3, 32'h0, 6'h3, 32'h0, 32, 0, 0);
        run(alu_pkg::OP_AND_W_ACC, 32'hff000ff0, 0, 6'h2, 32'hf00, 16, 4'h0, 4'he);
        run(alu_pkg::OP_XOR_W_ACC, 32'h80000001, 0, 6'h2, 32'h8001, 16, 4'h8, 4'he);
        run(alu_pkg::OP_OR_W_ACC, 32'h0, 32'h0, 6'h2, 32'h0, 16, 4'h4, 4'he);
        run(alu_pkg::OP_NOT_B, 32'h0, 32'hf, 6'h2, 32'hf0, 8, 4'h8, 4'he);
        run(alu_pkg::OP_NOT_W, 32'h0, 32'hffff, 6'h2, 32'h0, 16, 4'h4, 4'he);
        run(alu_pkg::OP_AND_L, 32'hffff0000, 32'h8000ffff, 6'h5, 32'h80000000, 32, 8, 4'he);
        run(alu_pkg::OP_OR_L, 32'h0, 32'h0, 6'h5, 32'h0, 32, 4'h4, 4'he);
        run(alu_pkg::OP_XOR_L, 32'h12345678, 32'h12345679, 6'h5, 32'h1, 32, 0, 4'he);
        run(alu_pkg::OP_TWOS_COMPLEMENT, 32'h80, 32'h80, 6'h2, 32'h80, 8, 4'hb, 4'hf);
        run(alu_pkg::OP_TWOS_COMPLEMENT, 32'h0, 32'h0, 6'h2, 32'h0, 8, 4'h4, 4'hf);
        {mem_operand_in, addr_cycles_in, access_corr_in} = 13'h1083;
        run(alu_pkg::OP_TWOS_COMPLEMENT_WORD, 1, 1, 6'hb, 32'hffff, 16, 4'h9, 4'hf);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a = seed[7:0];
            b = seed[15:8];
            r = (i % 3 == 0) ? (a & b) : (i % 3 == 1) ? (a | b) : (a ^ b);
            run(alu_pkg::alu_op_t'(alu_pkg::OP_AND_B + i % 3), {24'h0, a}, {24'h0, b}, 6'h2,
                {24'h0, r}, 8, {r[7], r == 8'h0, 2'h0}, 4'he);
        end
        report_and_stop();
    end
endmodule
